// ===== sflash_pkg.sv
// constants, register map and state type shared by the serial flash sequencer
package sflash_pkg;
	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] ADDR_XFER_CTRL = 32'h40012004; // counts and launch bit
	localparam logic [31:0] ADDR_READ_CTRL = 32'h40012008; // read byte count
	localparam logic [31:0] ADDR_CMD_LO = 32'h4001200c; // command bytes one to four
	localparam logic [31:0] ADDR_CMD_HI = 32'h40012010; // command bytes five to eight
	localparam logic [31:0] ADDR_DIR = 32'h40012014; // per byte direction mask
	localparam logic [31:0] ADDR_STAT = 32'h40012018; // sticky transaction status
	localparam logic [31:0] ADDR_BUF = 32'h4001201c; // buffer start address
	localparam logic [31:0] ADDR_IRQ_EN = 32'h40012030; // interrupt enable
	localparam logic [31:0] ADDR_IRQ_CLR = 32'h40012034; // write one to clear status
	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] DIR_RESET = 8'h0f; // bytes one to four sent
	localparam logic [2:0] CMD_COUNT_RESET = 3'h4; // default command length
	localparam int START_BIT = 7; // launch bit in control word
	localparam int CCNT_W = 3; // command count width
	localparam int WCNT_LSB = 8; // write count lsb in control word
	localparam int CNT_W = 24; // data count width
	localparam int FLAG_W = 2; // status flags
	localparam int DONE_BIT = 0; // transaction complete flag
	localparam int BERR_BIT = 1; // bus error flag
	localparam logic [7:0] RX_FILL = 8'h00; // sent while a byte is received
	localparam logic [2:0] BIT_LAST = 3'h7; // bits per byte minus one
	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_CS_SETUP, ST_CMD, ST_FETCH, ST_WDATA, ST_RDATA, ST_STORE, ST_CS_HOLD, ST_FINISH
	} seq_state_t;
endpackage

// ===== spi_byte_shift.sv
// one byte serial shifter, clock mode zero, msb first, two mclk cycles per bit
module spi_byte_shift (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [7:0] tx_byte,
	input wire logic miso_s,
	output logic sclk,
	output logic mosi,
	output logic done,
	output logic [7:0] rx_byte
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic busy_q; // byte in flight
	logic [2:0] cnt_q; // bits left minus one
	logic [7:0] sh_q; // outgoing shift register
	logic sclk_q; // serial clock level
	logic done_q; // one cycle end of byte
	logic [7:0] rx_q; // incoming shift register
	logic last_q; // eighth falling edge passed
	logic [1:0] smp_q; // sample strobe, delayed by the input synchroniser depth
	logic rise; // this cycle raises the serial clock

	// the input pin reaches us two cycles late, so each bit is taken two cycles after its rising edge
	assign rise = busy_q && !start && !sclk_q;

	// shift engine: low phase presents data, rising phase samples
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			busy_q <= 1'b0;
			cnt_q <= 3'h0;
			sh_q <= 8'h00;
			sclk_q <= 1'b0;
			done_q <= 1'b0;
			rx_q <= 8'h00;
			last_q <= 1'b0;
			smp_q <= 2'h0;
		end else begin
			// done rises on the same edge as the last delayed sample, so the received byte is whole
			done_q <= last_q;
			last_q <= 1'b0;
			smp_q <= {smp_q[0], rise};
			if (smp_q[1])
				rx_q <= {rx_q[6:0], miso_s};
			if (start) begin
				// load a fresh byte
				busy_q <= 1'b1;
				sh_q <= tx_byte;
				cnt_q <= sflash_pkg::BIT_LAST;
				sclk_q <= 1'b0;
			end else if (busy_q) begin
				if (!sclk_q) begin
					// rising edge, its bit is taken two cycles later
					sclk_q <= 1'b1;
				end else begin
					// falling edge, next bit or finish
					sclk_q <= 1'b0;
					if (cnt_q == 3'h0) begin
						busy_q <= 1'b0;
						last_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q - 3'h1;
						sh_q <= {sh_q[6:0], 1'b0};
					end
				end
			end
		end
	end

	assign sclk = sclk_q;
	assign mosi = sh_q[7];
	assign done = done_q;
	assign rx_byte = rx_q;
endmodule

// ===== serial_flash_controller.sv
// serial flash command sequencer with buffer transfer master and register port
//
// Implementation choice: the plain strobed port.
module serial_flash_controller (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic flash_sclk,
	output logic flash_ss_n,
	output logic flash_mosi,
	input wire logic flash_miso,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_req,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ready,
	input wire logic mem_err
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	sflash_pkg::seq_state_t state_q, state_d; // sequencer state
	logic start_q; // launch bit
	logic [sflash_pkg::CCNT_W-1:0] ccnt_q; // command byte count
	logic [sflash_pkg::CNT_W-1:0] wcnt_q; // bytes left to program
	logic [sflash_pkg::CNT_W-1:0] rcnt_q; // bytes left to read
	logic [63:0] cmd_q; // both command words
	logic [7:0] dir_q; // direction mask, one is send
	logic [31:0] buf_q; // buffer start address
	logic [sflash_pkg::FLAG_W-1:0] flags_q; // sticky status
	logic [sflash_pkg::FLAG_W-1:0] irq_en_q; // interrupt enable
	logic [sflash_pkg::FLAG_W-1:0] set_ev; // status events this cycle
	logic [sflash_pkg::FLAG_W-1:0] clr_ev; // status clears this cycle
	logic [31:0] rdata_q, rdata_d; // read data path
	logic [2:0] idx_q; // current command byte
	logic [31:0] off_q; // buffer offset
	logic [7:0] fetch_q; // byte fetched for programming
	logic [7:0] sh_tx; // byte offered to the shifter
	logic [7:0] sh_rx; // byte received by the shifter
	logic sh_start_q; // shifter load pulse
	logic sh_done; // shifter finished a byte
	logic sh_sclk, sh_mosi; // shifter pin drive
	logic ss_n_q; // chip select
	logic mem_req_q, mem_we_q; // memory request
	logic [31:0] mem_addr_q; // memory address
	logic [7:0] mem_wdata_q; // memory write byte
	logic miso_m, miso_s; // input synchroniser
	logic idle, finish, w_taken, r_stored, bus_err; // sequencer events
	sflash_pkg::seq_state_t data_nxt; // next step after command bytes

	assign idle = (state_q == sflash_pkg::ST_IDLE);
	assign finish = (state_q == sflash_pkg::ST_FINISH);
	assign w_taken = (state_q == sflash_pkg::ST_FETCH) && mem_ready;
	assign r_stored = (state_q == sflash_pkg::ST_STORE) && mem_ready;
	assign bus_err = mem_req_q && mem_ready && mem_err;

	// ----------------------------------------------------------------
	// control and count register
	// ----------------------------------------------------------------
	// launch and counts, written while idle, worked down, cleared at the end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			start_q <= 1'b0;
			ccnt_q <= sflash_pkg::CMD_COUNT_RESET;
			wcnt_q <= '0;
			rcnt_q <= '0;
		end else if (finish) begin
			start_q <= 1'b0;
			ccnt_q <= '0;
			wcnt_q <= '0;
			rcnt_q <= '0;
		end else if (idle && reg_wr && reg_addr == sflash_pkg::ADDR_XFER_CTRL) begin
			start_q <= reg_wdata[sflash_pkg::START_BIT];
			ccnt_q <= reg_wdata[sflash_pkg::CCNT_W-1:0];
			wcnt_q <= reg_wdata[sflash_pkg::WCNT_LSB +: sflash_pkg::CNT_W];
		end else if (idle && reg_wr && reg_addr == sflash_pkg::ADDR_READ_CTRL) begin
			rcnt_q <= reg_wdata[sflash_pkg::CNT_W-1:0];
		end else begin
			// one byte moved, one less to go
			if (w_taken)
				wcnt_q <= wcnt_q - 24'h000001;
			if (r_stored)
				rcnt_q <= rcnt_q - 24'h000001;
		end
	end

	// ----------------------------------------------------------------
	// command, direction and address registers
	// ----------------------------------------------------------------
	// received command bytes take priority over a software write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmd_q <= '0;
		end else if (state_q == sflash_pkg::ST_CMD && sh_done && !dir_q[idx_q]) begin
			cmd_q[{idx_q, 3'h0} +: 8] <= sh_rx;
		end else if (reg_wr && reg_addr == sflash_pkg::ADDR_CMD_LO) begin
			cmd_q[31:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == sflash_pkg::ADDR_CMD_HI) begin
			cmd_q[63:32] <= reg_wdata;
		end
	end

	// direction mask, buffer address and interrupt enable
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dir_q <= sflash_pkg::DIR_RESET;
			buf_q <= '0;
			irq_en_q <= '0;
		end else if (reg_wr) begin
			if (reg_addr == sflash_pkg::ADDR_DIR)
				dir_q <= reg_wdata[7:0];
			if (reg_addr == sflash_pkg::ADDR_BUF)
				buf_q <= reg_wdata;
			if (reg_addr == sflash_pkg::ADDR_IRQ_EN)
				irq_en_q <= reg_wdata[sflash_pkg::FLAG_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// status flags and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		set_ev = '0;
		set_ev[sflash_pkg::DONE_BIT] = finish;
		set_ev[sflash_pkg::BERR_BIT] = bus_err;
		clr_ev = '0;
		if (reg_rd && reg_addr == sflash_pkg::ADDR_STAT)
			clr_ev = '1;
		else if (reg_wr && reg_addr == sflash_pkg::ADDR_STAT)
			clr_ev = ~reg_wdata[sflash_pkg::FLAG_W-1:0];
		else if (reg_wr && reg_addr == sflash_pkg::ADDR_IRQ_CLR)
			clr_ev = reg_wdata[sflash_pkg::FLAG_W-1:0];
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			flags_q <= '0;
		else
			flags_q <= (flags_q & ~clr_ev) | set_ev;
	end

	assign irq = |(flags_q & irq_en_q);

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	always_comb begin
		rdata_d = '0;
		unique case (reg_addr)
			sflash_pkg::ADDR_XFER_CTRL: rdata_d = {wcnt_q, start_q, 4'h0, ccnt_q};
			sflash_pkg::ADDR_READ_CTRL: rdata_d = {8'h00, rcnt_q};
			sflash_pkg::ADDR_CMD_LO: rdata_d = cmd_q[31:0];
			sflash_pkg::ADDR_CMD_HI: rdata_d = cmd_q[63:32];
			sflash_pkg::ADDR_DIR: rdata_d = {24'h000000, dir_q};
			sflash_pkg::ADDR_STAT: rdata_d = {30'h00000000, flags_q};
			sflash_pkg::ADDR_BUF: rdata_d = buf_q;
			sflash_pkg::ADDR_IRQ_EN: rdata_d = {30'h00000000, irq_en_q};
			default: rdata_d = '0; // unmapped and write only read zero
		endcase
	end

	// read data only in the cycle after the strobe
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			rdata_q <= '0;
		else
			rdata_q <= reg_rd ? rdata_d : 32'h00000000;
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// after the command bytes: program first, then read, then release
	always_comb begin
		if (wcnt_q != '0)
			data_nxt = sflash_pkg::ST_FETCH;
		else if (rcnt_q != '0)
			data_nxt = sflash_pkg::ST_RDATA;
		else
			data_nxt = sflash_pkg::ST_CS_HOLD;
	end

	// next state, command phase first then data phase
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			sflash_pkg::ST_IDLE:
				if (start_q)
					state_d = sflash_pkg::ST_CS_SETUP;
			sflash_pkg::ST_CS_SETUP:
				state_d = (ccnt_q != '0) ? sflash_pkg::ST_CMD : data_nxt;
			sflash_pkg::ST_CMD:
				if (sh_done && (idx_q + 3'h1) == ccnt_q)
					state_d = data_nxt;
			sflash_pkg::ST_FETCH:
				if (mem_ready)
					state_d = sflash_pkg::ST_WDATA;
			sflash_pkg::ST_WDATA:
				if (sh_done)
					state_d = data_nxt;
			sflash_pkg::ST_RDATA:
				if (sh_done)
					state_d = sflash_pkg::ST_STORE;
			sflash_pkg::ST_STORE:
				if (mem_ready)
					state_d = (rcnt_q > 24'h000001) ? sflash_pkg::ST_RDATA : sflash_pkg::ST_CS_HOLD;
			sflash_pkg::ST_CS_HOLD:
				state_d = sflash_pkg::ST_FINISH;
			sflash_pkg::ST_FINISH:
				state_d = sflash_pkg::ST_IDLE;
		endcase
	end

	// state, byte index and buffer offset
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= sflash_pkg::ST_IDLE;
			idx_q <= 3'h0;
			off_q <= '0;
		end else begin
			state_q <= state_d;
			if (idle) begin
				idx_q <= 3'h0;
				off_q <= '0;
			end else begin
				if (state_q == sflash_pkg::ST_CMD && sh_done)
					idx_q <= idx_q + 3'h1;
				if (w_taken || r_stored)
					off_q <= off_q + 32'h00000001;
			end
		end
	end

	// shifter load on entry to a shift state or on a repeated command byte
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			sh_start_q <= 1'b0;
		else
			sh_start_q <= (state_d == sflash_pkg::ST_CMD || state_d == sflash_pkg::ST_WDATA ||
				state_d == sflash_pkg::ST_RDATA) && (state_d != state_q || sh_done);
	end

	// chip select low from setup through the last data byte
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			ss_n_q <= 1'b1;
		else
			ss_n_q <= (state_d == sflash_pkg::ST_IDLE || state_d == sflash_pkg::ST_CS_HOLD ||
				state_d == sflash_pkg::ST_FINISH);
	end

	// ----------------------------------------------------------------
	// buffer transfer master
	// ----------------------------------------------------------------
	// request held until ready; address latched on entry
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= '0;
			mem_wdata_q <= '0;
			fetch_q <= '0;
		end else begin
			mem_req_q <= (state_d == sflash_pkg::ST_FETCH || state_d == sflash_pkg::ST_STORE);
			mem_we_q <= (state_d == sflash_pkg::ST_STORE);
			if (state_d != state_q)
				mem_addr_q <= buf_q + off_q;
			if (w_taken)
				fetch_q <= mem_rdata;
			if (state_q == sflash_pkg::ST_RDATA && sh_done)
				mem_wdata_q <= sh_rx;
		end
	end

	assign mem_req = mem_req_q;
	assign mem_we = mem_we_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;

	// ----------------------------------------------------------------
	// serial side
	// ----------------------------------------------------------------
	// outgoing byte: masked command byte, fetched data or fill
	always_comb begin
		sh_tx = sflash_pkg::RX_FILL;
		if (state_q == sflash_pkg::ST_CMD && dir_q[idx_q])
			sh_tx = cmd_q[{idx_q, 3'h0} +: 8];
		else if (state_q == sflash_pkg::ST_WDATA)
			sh_tx = fetch_q;
	end

	// two flop synchroniser on the data input pin
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			miso_m <= 1'b0;
			miso_s <= 1'b0;
		end else begin
			miso_m <= flash_miso;
			miso_s <= miso_m;
		end
	end

	spi_byte_shift u_shift (
		.mclk(mclk),
		.resetn(resetn),
		.start(sh_start_q),
		.tx_byte(sh_tx),
		.miso_s(miso_s),
		.sclk(sh_sclk),
		.mosi(sh_mosi),
		.done(sh_done),
		.rx_byte(sh_rx)
	);

	assign flash_sclk = sh_sclk;
	assign flash_mosi = sh_mosi;
	assign flash_ss_n = ss_n_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// release then finish
	sequence s_release;
		state_q == sflash_pkg::ST_CS_HOLD ##1 state_q == sflash_pkg::ST_FINISH;
	endsequence

	// idle launch into setup
	sequence s_launch;
		idle && start_q ##1 state_q == sflash_pkg::ST_CS_SETUP;
	endsequence

	a_done_after_release: assert property (s_release |=> flags_q[sflash_pkg::DONE_BIT] && flash_ss_n)
		else $error("done flag not set after chip select release");
	a_done_needs_cs: assert property ($rose(flags_q[sflash_pkg::DONE_BIT]) |-> $past(ss_n_q, 2))
		else $error("done flag rose while chip select active");
	a_counts_cleared: assert property (finish |=> !start_q && ccnt_q == '0 && wcnt_q == '0 && rcnt_q == '0)
		else $error("launch bit or counts not cleared at completion");
	a_bus_error_flag: assert property (bus_err |=> flags_q[sflash_pkg::BERR_BIT])
		else $error("bus error response not flagged");
	a_read_clears: assert property (reg_rd && reg_addr == sflash_pkg::ADDR_STAT && set_ev == '0 |=> flags_q == '0)
		else $error("status not cleared by read");
	a_first_fetch_addr: assert property (s_launch ##0 (ccnt_q == '0 && wcnt_q != '0) |=> mem_req_q && mem_addr_q == buf_q)
		else $error("first fetch not at buffer start");
	a_cmd_send_byte: assert property (sh_start_q && state_q == sflash_pkg::ST_CMD && dir_q[idx_q] |=>
		flash_mosi == $past(cmd_q[{idx_q, 3'h7}]))
		else $error("sent command byte does not match buffer");
	a_cmd_rx_store: assert property (state_q == sflash_pkg::ST_CMD && sh_done && !dir_q[idx_q] |=> cmd_q[{$past(idx_q), 3'h0} +: 8] == $past(sh_rx))
		else $error("received command byte not stored");
	a_cs_during_data: assert property (mem_req_q |-> !flash_ss_n && !idle)
		else $error("memory transfer outside a transaction");
	a_upper_write: assert property (reg_wr && reg_addr == sflash_pkg::ADDR_CMD_HI && idle |=> cmd_q[63:32] == $past(reg_wdata))
		else $error("upper command word not written");
	a_wcount_dec: assert property (w_taken && !finish |=> wcnt_q == $past(wcnt_q) - 24'h000001)
		else $error("write count not decremented");
	a_rcount_load: assert property (idle && reg_wr && reg_addr == sflash_pkg::ADDR_READ_CTRL |=> rcnt_q == $past(reg_wdata[23:0]))
		else $error("read count not loaded");
	a_cmd_count_load: assert property (idle && !finish && reg_wr && reg_addr == sflash_pkg::ADDR_XFER_CTRL |=> ccnt_q == $past(reg_wdata[2:0]))
		else $error("command count not loaded");
endmodule

// ===== sflash_model.sv
// behavioural serial flash: records bytes on mosi, answers a counting pattern on miso
module sflash_model (
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_sh; // incoming shift
	logic [7:0] tx_sh; // outgoing shift
	int bits; // bits of current byte
	int idx; // byte index in frame
	logic [7:0] got [$]; // bytes seen in this frame
	initial miso = 1'b0;
	// frame start: clear record, present first reply bit
	always @(negedge ss_n) begin
		got.delete();
		bits = 0;
		idx = 0;
		tx_sh = 8'ha0;
		miso = tx_sh[7];
	end
	// mode zero: sample on rising clock
	always @(posedge sclk) if (!ss_n) begin
		rx_sh = {rx_sh[6:0], mosi};
		bits = bits + 1;
		if (bits == 8) begin
			got.push_back(rx_sh);
			bits = 0;
			idx = idx + 1;
		end
	end
	// shift out on falling clock, next byte after eighth bit
	always @(negedge sclk) if (!ss_n) begin
		tx_sh = (bits == 0) ? 8'ha0 + idx[7:0] : {tx_sh[6:0], 1'b0};
		miso = tx_sh[7];
	end
	// released line has no pull: show the inverse
	always @(posedge ss_n) miso = ~miso;
endmodule

// ===== tb.sv
// self-checking testbench for the serial flash sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic wr; logic [31:0] addr; logic [31:0] data;} row_t;
	logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mem_ready = 1'b0, mem_err = 1'b0;
	logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, mem_addr, rdv;
	logic [31:0] err_addr = 32'hffffffff; // address answered with an error
	logic [7:0] mem_rdata = 8'h0, mem_wdata;
	logic [7:0] mem [0:15]; // buffer memory, low nibble indexed
	logic [7:0] exp_tx [0:9] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h66, 8'hd0, 8'hd1, 8'h00, 8'h00};
	logic irq, flash_sclk, flash_ss_n, flash_mosi, flash_miso, mem_we, mem_req;
	int mismatches = 0, check_count = 0, cycles = 0, stall = 0;
	row_t rows [16] = '{
		'{1'b0, sflash_pkg::ADDR_XFER_CTRL, 32'h4}, '{1'b0, sflash_pkg::ADDR_READ_CTRL, 32'h0},
		'{1'b0, sflash_pkg::ADDR_CMD_LO, 32'h0}, '{1'b0, sflash_pkg::ADDR_CMD_HI, 32'h0},
		'{1'b0, sflash_pkg::ADDR_DIR, 32'hf}, '{1'b0, sflash_pkg::ADDR_STAT, 32'h0},
		'{1'b0, sflash_pkg::ADDR_BUF, 32'h0}, '{1'b0, sflash_pkg::ADDR_IRQ_EN, 32'h0},
		'{1'b1, sflash_pkg::ADDR_CMD_HI, 32'h87654321}, '{1'b0, sflash_pkg::ADDR_CMD_HI, 32'h87654321},
		'{1'b1, sflash_pkg::ADDR_DIR, 32'h1ff}, '{1'b0, sflash_pkg::ADDR_DIR, 32'hff},
		'{1'b1, sflash_pkg::ADDR_BUF, 32'h20000100}, '{1'b0, sflash_pkg::ADDR_BUF, 32'h20000100},
		'{1'b0, 32'h40012040, 32'h0}, '{1'b0, sflash_pkg::ADDR_IRQ_CLR, 32'h0}};
	// ----------------------------------------------------------------
	// clock, design, far side
	// ----------------------------------------------------------------
	always #10 mclk = ~mclk;
	serial_flash_controller i_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .flash_sclk(flash_sclk),
		.flash_ss_n(flash_ss_n), .flash_mosi(flash_mosi), .flash_miso(flash_miso), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.mem_ready(mem_ready), .mem_err(mem_err));
	sflash_model i_flash (.sclk(flash_sclk), .ss_n(flash_ss_n), .mosi(flash_mosi), .miso(flash_miso));
	// memory slave: three wait cycles per request, stale data inverted
	always @(posedge mclk) begin
		mem_ready <= 1'b0;
		mem_err <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ready) begin
			stall <= (stall < 2) ? stall + 1 : 0;
			if (stall == 2) begin
				mem_ready <= 1'b1;
				mem_rdata <= mem[mem_addr[3:0]];
				mem_err <= (mem_addr === err_addr);
			end
		end
		if (mem_req && mem_ready && mem_we) mem[mem_addr[3:0]] <= mem_wdata;
	end
	// hang guard
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	task automatic wait_irq;
		int n;
		for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic do_reset;
		resetn <= 1'b0;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		mem[0] = 8'hd0;
		mem[1] = 8'hd1;
		do_reset();
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].addr, rows[i].data);
			else begin
				rd(rows[i].addr, rdv);
				chk(rdv, rows[i].data);
			end
		end
		$display("test register table done");
		// six command bytes, byte five received, two written, two read
		wr(sflash_pkg::ADDR_CMD_LO, 32'h44332211);
		wr(sflash_pkg::ADDR_CMD_HI, 32'h00006600);
		wr(sflash_pkg::ADDR_DIR, 32'h2f);
		wr(sflash_pkg::ADDR_IRQ_EN, 32'h1);
		wr(sflash_pkg::ADDR_READ_CTRL, 32'h2);
		wr(sflash_pkg::ADDR_XFER_CTRL, 32'h286);
		wait_irq();
		chk(irq, 1'b1);
		chk(flash_ss_n, 1'b1);
		chk(i_flash.got.size(), 10);
		foreach (exp_tx[k]) chk(i_flash.got[k], exp_tx[k]);
		chk(mem[2], 8'ha8);
		chk(mem[3], 8'ha9);
		rd(sflash_pkg::ADDR_CMD_HI, rdv);
		chk(rdv, 32'h000066a4);
		rd(sflash_pkg::ADDR_XFER_CTRL, rdv);
		chk(rdv, 32'h0);
		rd(sflash_pkg::ADDR_READ_CTRL, rdv);
		chk(rdv, 32'h0);
		rd(sflash_pkg::ADDR_STAT, rdv);
		chk(rdv, 32'h1);
		rd(sflash_pkg::ADDR_STAT, rdv);
		chk(rdv, 32'h0);
		chk(irq, 1'b0);
		$display("test full transaction done");
		// no command bytes, fetch answered with an error, then done cleared by writing zero
		err_addr = 32'h20000100;
		wr(sflash_pkg::ADDR_DIR, 32'hff);
		wr(sflash_pkg::ADDR_XFER_CTRL, 32'h180);
		wait_irq();
		wr(sflash_pkg::ADDR_STAT, 32'h2);
		@(negedge mclk);
		chk(irq, 1'b0);
		rd(sflash_pkg::ADDR_STAT, rdv);
		chk(rdv, 32'h2);
		$display("test bus error done");
		// busy refusal, then reset in mid transaction
		wr(sflash_pkg::ADDR_XFER_CTRL, 32'h181);
		wr(sflash_pkg::ADDR_READ_CTRL, 32'h5);
		rd(sflash_pkg::ADDR_READ_CTRL, rdv);
		chk(rdv, 32'h0);
		do_reset();
		@(negedge mclk);
		chk(flash_ss_n, 1'b1);
		rd(sflash_pkg::ADDR_XFER_CTRL, rdv);
		chk(rdv, 32'h4);
		rd(sflash_pkg::ADDR_DIR, rdv);
		chk(rdv, 32'hf);
		$display("test busy and reset done");
		complete_run();
	end
endmodule
